// ===== hw/bsp_pkg.sv
// Operation
// - Reads leave on their own output pins and writes arrive on their own input pins.
// - One address bus carries read and write addresses on alternate true-clock rises.
// - Each address holds a burst of four words moved one after another.
// - Burst words move on every rise of the true and of the complement clock.
// - Only rising clock edges are used.
// - With the strap high the first read word appears 2.5 cycles after the address.
// - With the strap low the first read word appears 1 cycle after the address.
// - Address, selects, byte selects and write data are registered on the input clocks.
// - Read data leaves from registers on the input clocks.
// - Writes are committed to the array by internal timing.
// - Read and write ports have separate selects and act independently.
// - A valid flag marks each read word on the output pins.
// - Echo clocks change together with the read data.
// - A read sees writes accepted at least two slot pairs earlier, including those not yet committed.
package bsp_pkg;
    localparam int unsigned DATA_W_DEF    = 18;
    localparam int unsigned ADDR_W_DEF    = 20;
    localparam int unsigned BUF_DEPTH_DEF = 2;
    localparam int unsigned BURST_LEN     = 4;
    localparam int unsigned LANE_BITS     = 9;
    // Read latency in half cycles of the input clock
    localparam int unsigned LAT_SHORT_HALF = 2;
    localparam int unsigned LAT_LONG_HALF  = 5;
    // Address slot of each true-clock rise
    typedef enum logic {
        BSP_SLOT_RD = 1'b0,
        BSP_SLOT_WR = 1'b1
    } bsp_slot_t;
endpackage

// ===== hw/bsp_sram.sv
`timescale 1ns/1ns
`default_nettype none
module bsp_sram #(
    parameter int unsigned DATA_W    = bsp_pkg::DATA_W_DEF,
    parameter int unsigned ADDR_W    = bsp_pkg::ADDR_W_DEF,
    parameter int unsigned BUF_DEPTH = bsp_pkg::BUF_DEPTH_DEF
) (
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 pll_disable_pin_i,
    input  wire logic                 k_clk_i,
    input  wire logic                 kn_clk_i,
    input  wire logic [ADDR_W-1:0]    addr_i,
    input  wire logic                 rsel_n_i,
    input  wire logic                 wsel_n_i,
    input  wire logic [DATA_W/9-1:0]  byte_write_select_n_i,
    input  wire logic [DATA_W-1:0]    wdata_i,
    output logic      [DATA_W-1:0]    rdata_k_o,
    output logic      [DATA_W-1:0]    rdata_kn_o,
    output logic                      read_data_valid_flag_k_o,
    output logic                      read_data_valid_flag_kn_o,
    output logic                      echo_clock_pair_t_o,
    output logic                      echo_clock_pair_c_o
);
    localparam int unsigned NB    = DATA_W / bsp_pkg::LANE_BITS;
    localparam int unsigned BL    = bsp_pkg::BURST_LEN;
    localparam int unsigned BW    = BL * DATA_W;
    localparam int unsigned PW    = $clog2(BUF_DEPTH);
    localparam int unsigned DEPTH = 2 ** ADDR_W;

    // -----------------------------------------------------------
    // Lane merge
    // -----------------------------------------------------------
    function automatic logic [BW-1:0] merge_f(input logic [BW-1:0] base,
                                              input logic [BW-1:0] upd,
                                              input logic [BL*NB-1:0] en);
        logic [BW-1:0] res;
        res = base;
        for (int i = 0; i < BL * NB; i++) begin
            if (en[i]) begin
                res[i*bsp_pkg::LANE_BITS +: bsp_pkg::LANE_BITS] =
                    upd[i*bsp_pkg::LANE_BITS +: bsp_pkg::LANE_BITS];
            end
        end
        return res;
    endfunction

    // -----------------------------------------------------------
    // Reset and strap crossing
    // -----------------------------------------------------------
    logic [1:0] sys_rst_q;
    logic [1:0] k_rst_q;
    logic [1:0] kn_rst_q;
    logic       pll_meta_q;
    logic       pll_sys_q;
    logic       pll_kmeta_q;
    logic       long_q;
    logic       sys_rstn;
    logic       k_rstn;
    logic       kn_rstn;
    assign sys_rstn = sys_rst_q[1];
    assign k_rstn   = k_rst_q[1];
    assign kn_rstn  = kn_rst_q[1];

    // System reset release, two stages
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sys_rst_q <= 2'h0;
        end else begin
            sys_rst_q <= {sys_rst_q[0], 1'b1};
        end
    end

    // Latency strap is a pin: two stages here, two more in the link domain before use
    always_ff @(posedge clk_i or negedge sys_rstn) begin
        if (!sys_rstn) begin
            pll_meta_q <= 1'b0;
            pll_sys_q  <= 1'b0;
        end else begin
            pll_meta_q <= pll_disable_pin_i;
            pll_sys_q  <= pll_meta_q;
        end
    end

    // Link resets assert at once, release on the link's own clocks
    always_ff @(posedge k_clk_i or negedge sys_rstn) begin
        if (!sys_rstn) begin
            k_rst_q <= 2'h0;
        end else begin
            k_rst_q <= {k_rst_q[0], 1'b1};
        end
    end

    always_ff @(posedge kn_clk_i or negedge sys_rstn) begin
        if (!sys_rstn) begin
            kn_rst_q <= 2'h0;
        end else begin
            kn_rst_q <= {kn_rst_q[0], 1'b1};
        end
    end

    // Strap level into the link domain
    always_ff @(posedge k_clk_i or negedge k_rstn) begin
        if (!k_rstn) begin
            pll_kmeta_q <= 1'b0;
            long_q      <= 1'b0;
        end else begin
            pll_kmeta_q <= pll_sys_q;
            long_q      <= pll_kmeta_q;
        end
    end

    // -----------------------------------------------------------
    // Input registers
    // -----------------------------------------------------------
    bsp_pkg::bsp_slot_t slot_q;
    logic [ADDR_W-1:0]  addr_q;
    logic               rsel_n_q;
    logic               wsel_n_q;
    logic [DATA_W-1:0]  wd_k_q;
    logic [NB-1:0]      bws_k_q;
    logic [DATA_W-1:0]  wd_kn_q;
    logic [NB-1:0]      bws_kn_q;
    logic               rd_acc;
    logic               wr_acc;

    // True-clock capture; slot alternates read, write
    always_ff @(posedge k_clk_i or negedge k_rstn) begin
        if (!k_rstn) begin
            slot_q   <= bsp_pkg::BSP_SLOT_WR;
            addr_q   <= '0;
            rsel_n_q <= 1'b1;
            wsel_n_q <= 1'b1;
            wd_k_q   <= '0;
            bws_k_q  <= '1;
        end else begin
            slot_q   <= (slot_q == bsp_pkg::BSP_SLOT_RD) ? bsp_pkg::BSP_SLOT_WR
                                                          : bsp_pkg::BSP_SLOT_RD;
            addr_q   <= addr_i;
            rsel_n_q <= rsel_n_i;
            wsel_n_q <= wsel_n_i;
            wd_k_q   <= wdata_i;
            bws_k_q  <= byte_write_select_n_i;
        end
    end

    // Complement-clock capture of odd write words
    always_ff @(posedge kn_clk_i or negedge kn_rstn) begin
        if (!kn_rstn) begin
            wd_kn_q  <= '0;
            bws_kn_q <= '1;
        end else begin
            wd_kn_q  <= wdata_i;
            bws_kn_q <= byte_write_select_n_i;
        end
    end

    // Each select only counts in its own slot
    assign rd_acc = (slot_q == bsp_pkg::BSP_SLOT_RD) && !rsel_n_q;
    assign wr_acc = (slot_q == bsp_pkg::BSP_SLOT_WR) && !wsel_n_q;

    // -----------------------------------------------------------
    // Write burst assembly and buffer
    // -----------------------------------------------------------
    logic                wp1_q;
    logic                wp2_q;
    logic [ADDR_W-1:0]   wa1_q;
    logic [ADDR_W-1:0]   wa2_q;
    logic [2*DATA_W-1:0] pair_q;
    logic [2*NB-1:0]     pair_en_q;
    logic                hold_v_q;
    logic [ADDR_W-1:0]   hold_addr_q;
    logic [BW-1:0]       hold_data_q;
    logic [BL*NB-1:0]    hold_en_q;
    logic [ADDR_W-1:0]   e_addr_q [BUF_DEPTH];
    logic [BW-1:0]       e_data_q [BUF_DEPTH];
    logic [BL*NB-1:0]    e_en_q   [BUF_DEPTH];
    logic [PW-1:0]       wptr_q;
    logic [PW-1:0]       rptr_q;
    logic [PW:0]         cnt_q;
    logic                push;
    logic                pop;
    logic [BW-1:0]       mem_q [DEPTH];

    // Filling side ready is room in the buffer; drain stalls on accepted reads
    assign push = hold_v_q && (cnt_q < (PW+1)'(BUF_DEPTH));
    assign pop  = (cnt_q != '0) && !rd_acc;

    // Words 0,1 after one more rise, words 2,3 after the next
    always_ff @(posedge k_clk_i or negedge k_rstn) begin
        if (!k_rstn) begin
            wp1_q       <= 1'b0;
            wp2_q       <= 1'b0;
            wa1_q       <= '0;
            wa2_q       <= '0;
            pair_q      <= '0;
            pair_en_q   <= '0;
            hold_v_q    <= 1'b0;
            hold_addr_q <= '0;
            hold_data_q <= '0;
            hold_en_q   <= '0;
        end else begin
            wp1_q <= wr_acc;
            wa1_q <= addr_q;
            wp2_q <= wp1_q;
            if (wp1_q) begin
                wa2_q     <= wa1_q;
                pair_q    <= {wd_kn_q, wd_k_q};
                pair_en_q <= ~{bws_kn_q, bws_k_q};
            end
            if (wp2_q) begin
                hold_v_q    <= 1'b1;
                hold_addr_q <= wa2_q;
                hold_data_q <= {wd_kn_q, wd_k_q, pair_q};
                hold_en_q   <= {~bws_kn_q, ~bws_k_q, pair_en_q};
            end else if (push) begin
                hold_v_q <= 1'b0;
            end
        end
    end

    // Two-entry buffer pointers
    always_ff @(posedge k_clk_i or negedge k_rstn) begin
        if (!k_rstn) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Buffer storage of address, data and lane enables
    always_ff @(posedge k_clk_i) begin
        if (push) begin
            e_addr_q[wptr_q] <= hold_addr_q;
            e_data_q[wptr_q] <= hold_data_q;
            e_en_q[wptr_q]   <= hold_en_q;
        end
    end

    // Self-timed commit, one burst per free array slot
    always_ff @(posedge k_clk_i) begin
        if (pop) begin
            mem_q[e_addr_q[rptr_q]] <= merge_f(mem_q[e_addr_q[rptr_q]],
                                               e_data_q[rptr_q],
                                               e_en_q[rptr_q]);
        end
    end

    // -----------------------------------------------------------
    // Read lookup and output pipeline
    // -----------------------------------------------------------
    logic [BW-1:0]     look_d;
    logic [PW-1:0]     idx;
    logic              r1_q;
    logic              r2_q;
    logic              r3_q;
    logic [BW-1:0]     rb_q;
    logic [BW-1:0]     rb2_q;
    logic [DATA_W-1:0] kn_next_q;
    logic              knv_q;

    // Array word overlaid by pending writes, oldest first
    always_comb begin
        idx    = '0;
        look_d = mem_q[addr_q];
        for (int j = 0; j < BUF_DEPTH; j++) begin
            idx = rptr_q + PW'(j);
            if ((j < cnt_q) && (e_addr_q[idx] == addr_q)) begin
                look_d = merge_f(look_d, e_data_q[idx], e_en_q[idx]);
            end
        end
        if (hold_v_q && (hold_addr_q == addr_q)) begin
            look_d = merge_f(look_d, hold_data_q, hold_en_q);
        end
    end

    // Burst copies kept per stage so reads may follow every two cycles
    always_ff @(posedge k_clk_i or negedge k_rstn) begin
        if (!k_rstn) begin
            r1_q  <= 1'b0;
            r2_q  <= 1'b0;
            r3_q  <= 1'b0;
            rb_q  <= '0;
            rb2_q <= '0;
        end else begin
            r1_q <= rd_acc;
            r2_q <= r1_q;
            r3_q <= r2_q;
            if (rd_acc) begin
                rb_q <= look_d;
            end
            if (r1_q) begin
                rb2_q <= rb_q;
            end
        end
    end

    // True-clock read words; odd slots prepared for the complement clock
    always_ff @(posedge k_clk_i or negedge k_rstn) begin
        if (!k_rstn) begin
            rdata_k_o                <= '0;
            read_data_valid_flag_k_o <= 1'b0;
            kn_next_q                <= '0;
            knv_q                    <= 1'b0;
            echo_clock_pair_t_o      <= 1'b0;
        end else begin
            read_data_valid_flag_k_o <= 1'b0;
            knv_q                    <= 1'b0;
            echo_clock_pair_t_o      <= !echo_clock_pair_t_o;
            if (!long_q) begin
                if (rd_acc) begin
                    rdata_k_o                <= look_d[0 +: DATA_W];
                    read_data_valid_flag_k_o <= 1'b1;
                    kn_next_q                <= look_d[DATA_W +: DATA_W];
                    knv_q                    <= 1'b1;
                end
                if (r1_q) begin
                    rdata_k_o                <= rb_q[2*DATA_W +: DATA_W];
                    read_data_valid_flag_k_o <= 1'b1;
                    kn_next_q                <= rb_q[3*DATA_W +: DATA_W];
                    knv_q                    <= 1'b1;
                end
            end else begin
                if (r1_q) begin
                    kn_next_q <= rb_q[0 +: DATA_W];
                    knv_q     <= 1'b1;
                end
                if (r2_q) begin
                    rdata_k_o                <= rb2_q[DATA_W +: DATA_W];
                    read_data_valid_flag_k_o <= 1'b1;
                    kn_next_q                <= rb2_q[2*DATA_W +: DATA_W];
                    knv_q                    <= 1'b1;
                end
                if (r3_q) begin
                    rdata_k_o                <= rb2_q[3*DATA_W +: DATA_W];
                    read_data_valid_flag_k_o <= 1'b1;
                end
            end
        end
    end

    // Complement-clock output registers, half a cycle after preparation
    always_ff @(posedge kn_clk_i or negedge kn_rstn) begin
        if (!kn_rstn) begin
            rdata_kn_o                <= '0;
            read_data_valid_flag_kn_o <= 1'b0;
            echo_clock_pair_c_o       <= 1'b0;
        end else begin
            rdata_kn_o                <= kn_next_q;
            read_data_valid_flag_kn_o <= knv_q;
            echo_clock_pair_c_o       <= !echo_clock_pair_c_o;
        end
    end

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    sequence short_burst_s;
        (read_data_valid_flag_k_o && read_data_valid_flag_kn_o) [*2];
    endsequence

    sequence long_burst_s;
        read_data_valid_flag_kn_o ##1
        (read_data_valid_flag_k_o && read_data_valid_flag_kn_o) ##1
        read_data_valid_flag_k_o;
    endsequence

    short_latency_a:
    assert property (@(posedge k_clk_i) disable iff (!k_rstn)
        (rd_acc && !long_q) |-> ##1 short_burst_s)
    else $error("short latency read burst misplaced");

    long_latency_a:
    assert property (@(posedge k_clk_i) disable iff (!k_rstn)
        (rd_acc && long_q && $stable(long_q)) |-> ##2 long_burst_s)
    else $error("long latency read burst misplaced");

    burst_order_a:
    assert property (@(posedge k_clk_i) disable iff (!k_rstn)
        (rd_acc && !long_q) |-> ##2 (rdata_k_o == rb_q[2*DATA_W +: DATA_W]))
    else $error("third burst word out of order");

    slot_alternate_a:
    assert property (@(posedge k_clk_i) disable iff (!k_rstn)
        $past(k_rstn) |-> (slot_q != $past(slot_q)))
    else $error("address slot did not alternate");

    echo_toggle_a:
    assert property (@(posedge kn_clk_i) disable iff (!kn_rstn)
        $past(kn_rstn) |-> (echo_clock_pair_c_o != $past(echo_clock_pair_c_o)))
    else $error("echo clock stalled");

    write_capture_a:
    assert property (@(posedge k_clk_i) disable iff (!k_rstn)
        wr_acc |-> ##1 wp1_q ##1 wp2_q ##1 hold_v_q)
    else $error("write burst not assembled in time");

    buffer_fill_a:
    assert property (@(posedge k_clk_i) disable iff (!k_rstn)
        (push && !pop) |=> (cnt_q == $past(cnt_q) + 1'b1))
    else $error("buffer count missed a push");

    buffer_drain_a:
    assert property (@(posedge k_clk_i) disable iff (!k_rstn)
        (pop && !push) |=> (cnt_q + 1'b1 == $past(cnt_q)))
    else $error("buffer count missed a commit");

    newest_data_a:
    assert property (@(posedge k_clk_i) disable iff (!k_rstn)
        (rd_acc && hold_v_q && (hold_addr_q == addr_q) && (&hold_en_q))
        |=> (rb_q == $past(hold_data_q)))
    else $error("read missed pending write data");
endmodule
`default_nettype wire

// ===== tb/bsp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module bsp_ctrl_model #(
    parameter int AW = 6,
    parameter int DW = 18
) (
    output logic               k_clk_o,
    output logic               kn_clk_o,
    output logic [AW-1:0]      addr_o,
    output logic               rsel_n_o,
    output logic               wsel_n_o,
    output logic [DW/9-1:0]    bws_n_o,
    output logic [DW-1:0]      wdata_o,
    input  wire logic [DW-1:0] rdata_k_i,
    input  wire logic [DW-1:0] rdata_kn_i,
    input  wire logic          vld_k_i,
    input  wire logic          vld_kn_i,
    input  wire logic          echo_t_i,
    input  wire logic          echo_c_i
);
    // ----------------------------------------
    // Controller side of the link
    // ----------------------------------------
    int            hc = 0;
    logic [DW-1:0] got_d[$];
    int            got_h[$];

    // Idle pins at time zero, then a free-running 160 ns link clock
    initial begin
        addr_o = '0;
        rsel_n_o = 1'b1;
        wsel_n_o = 1'b1;
        bws_n_o = '1;
        wdata_o = '0;
        k_clk_o = 1'b0;
        #37;
        forever #80 k_clk_o = ~k_clk_o;
    end
    assign kn_clk_o = ~k_clk_o;

    // Half-cycle counter, used only to time the read words
    always @(posedge k_clk_o or posedge kn_clk_o) hc <= hc + 1;

    // Echo edges capture words, but only while flagged valid
    always @(echo_t_i) begin
        #1;
        if (vld_k_i === 1'b1) begin
            got_d.push_back(rdata_k_i);
            got_h.push_back(hc);
        end
    end
    always @(echo_c_i) begin
        #1;
        if (vld_kn_i === 1'b1) begin
            got_d.push_back(rdata_kn_i);
            got_h.push_back(hc);
        end
    end

    // Four words on alternating clock rises after the write address
    task automatic send(input logic [4*DW-1:0] wd, input logic [4*(DW/9)-1:0] bw);
        for (int i = 0; i < 4; i++) begin
            if (i % 2 == 0) @(posedge kn_clk_o);
            else @(posedge k_clk_o);
            #1;
            wdata_o = wd[i*DW +: DW];
            bws_n_o = bw[i*(DW/9) +: DW/9];
        end
    endtask

    // Read slot then write slot; a stray select sits in the other slot
    task automatic pair(input logic rd, input logic [AW-1:0] ra, input logic wr,
                        input logic [AW-1:0] wa, input logic [4*DW-1:0] wd,
                        input logic [4*(DW/9)-1:0] bw, input logic [1:0] junk,
                        output int rh);
        if (echo_t_i !== 1'b0) begin
            @(posedge k_clk_o);
            #1;
        end
        addr_o = ra;
        rsel_n_o = ~rd;
        wsel_n_o = junk[0];
        @(posedge k_clk_o);
        #1;
        rh = hc;
        addr_o = wa;
        rsel_n_o = junk[1];
        wsel_n_o = ~wr;
        @(posedge k_clk_o);
        #1;
        fork
            send(wd, bw);
        join_none
    endtask

    // Both selects released, so nothing is taken across a reset
    task automatic quiet();
        @(posedge k_clk_o);
        #1;
        rsel_n_o = 1'b1;
        wsel_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ----------------------------------------
    // Bench, reference memory and checks
    // ----------------------------------------
    localparam int AW = 6;
    localparam int DW = 18;
    localparam int NB = DW / 9;
    typedef struct packed {
        logic              en;
        logic [AW-1:0]     a;
        logic [4*DW-1:0]   d;
        logic [4*NB-1:0]   b;
    } bsp_tbwr_t;

    logic          clk_i = 1'b0;
    logic          rstn = 1'b0;
    logic          strap = 1'b0;
    wire logic     k, kn, rsel_n, wsel_n, vk, vkn, et, ec;
    wire logic [AW-1:0] addr;
    wire logic [NB-1:0] bws_n;
    wire logic [DW-1:0] wd, rk, rkn;
    int            n_fail = 0;
    int            tests_run = 0;
    int            lat = 0;
    logic [15:0]   lf = 16'hD54C;
    logic [DW-1:0] mem [0:(1<<AW)*4-1];
    logic [DW-1:0] exp_d[$];
    int            exp_h[$];
    bsp_tbwr_t     wq[$];

    always #2 clk_i = ~clk_i;

    bsp_sram #(.ADDR_W(AW)) DUT (
        .clk_i(clk_i), .rstn_i(rstn), .pll_disable_pin_i(strap),
        .k_clk_i(k), .kn_clk_i(kn), .addr_i(addr), .rsel_n_i(rsel_n), .wsel_n_i(wsel_n),
        .byte_write_select_n_i(bws_n), .wdata_i(wd), .rdata_k_o(rk), .rdata_kn_o(rkn),
        .read_data_valid_flag_k_o(vk), .read_data_valid_flag_kn_o(vkn),
        .echo_clock_pair_t_o(et), .echo_clock_pair_c_o(ec)
    );
    bsp_ctrl_model #(.AW(AW), .DW(DW)) u_ctrl (
        .k_clk_o(k), .kn_clk_o(kn), .addr_o(addr), .rsel_n_o(rsel_n), .wsel_n_o(wsel_n),
        .bws_n_o(bws_n), .wdata_o(wd), .rdata_k_i(rk), .rdata_kn_i(rkn),
        .vld_k_i(vk), .vld_kn_i(vkn), .echo_t_i(et), .echo_c_i(ec)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic cmp_word(input logic [DW-1:0] g, input logic [DW-1:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_num(input int g, input int e);
        tests_run++;
        if (g != e) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Oldest pending write lands in the reference, lane by lane
    task automatic commit();
        bsp_tbwr_t w;
        w = wq.pop_front();
        for (int i = 0; i < 4; i++)
            for (int b = 0; b < NB; b++)
                if (w.en && !w.b[i*NB+b]) mem[w.a*4+i][b*9 +: 9] = w.d[i*DW+b*9 +: 9];
    endtask

    // One slot pair; a write only shows to reads two pairs later
    task automatic op(input logic rd, input logic wr, input logic nar, input int fa);
        bsp_tbwr_t     w;
        logic [AW-1:0] ra;
        int            rh;
        lf = lfsr(lf);
        ra = nar ? AW'(lf[2:0]) : lf[AW-1:0];
        w.en = wr;
        w.a = (fa >= 0) ? AW'(fa) : (nar ? AW'(lf[5:3]) : lf[11:6]);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            w.d[i*DW +: DW] = DW'({lf, lf});
        end
        lf = lfsr(lf);
        w.b = nar ? lf[4*NB-1:0] : '0;
        if (wq.size() == 2) commit();
        // Idle pairs leave no stray read select behind for the next slot
        u_ctrl.pair(rd, ra, wr, w.a, w.d, w.b, (rd | wr) ? lf[9:8] : 2'h3, rh);
        if (rd) for (int i = 0; i < 4; i++) begin
            exp_d.push_back(mem[ra*4+i]);
            exp_h.push_back(rh + lat + i);
        end
        wq.push_back(w);
    endtask

    // Drain traffic, then match every captured word in order
    task automatic flush_check();
        repeat (3) op(1'b0, 1'b0, 1'b0, -1);
        u_ctrl.quiet();
        while (wq.size() > 0) commit();
        repeat (4) @(posedge k);
        cmp_num(u_ctrl.got_d.size(), exp_d.size());
        while (exp_d.size() > 0 && u_ctrl.got_d.size() > 0) begin
            cmp_word(u_ctrl.got_d.pop_front(), exp_d.pop_front());
            cmp_num(u_ctrl.got_h.pop_front(), exp_h.pop_front());
        end
        u_ctrl.got_d.delete();
        u_ctrl.got_h.delete();
        exp_d.delete();
        exp_h.delete();
    endtask

    // Reset with the strap set, then random mixed traffic
    task automatic phase(input logic s, input logic fill);
        @(posedge clk_i);
        #1;
        rstn = 1'b0;
        strap = s;
        repeat (16) @(posedge clk_i);
        #1;
        rstn = 1'b1;
        lat = s ? bsp_pkg::LAT_LONG_HALF : bsp_pkg::LAT_SHORT_HALF;
        repeat (8) @(posedge k);
        #1;
        if (fill) for (int a = 0; a < (1 << AW); a++) op(1'b0, 1'b1, 1'b0, a);
        repeat (150) begin
            lf = lfsr(lf);
            op(lf[12] | lf[14], lf[13] | lf[3], lf[15] | lf[11], -1);
        end
        flush_check();
    endtask

    // Short latency first, then a mid-run reset into long latency
    initial begin
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b0);
        print_verdict();
    end

    // Hang guard, far beyond the expected run time
    initial begin
        #300000;
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
